//--- logic/mce_counter.sv
// Operation
// - Total keeps counting through reset one
// - Total reset input clears total count
// - Panel reset on total clears all
// - Total spans -99999..999999, wraps to zero counting up, holds at -99999 counting down
// - Batch increments at each completion only
// - Batch output held until batch reset
// - Panel reset on batch screen clears all
// - Batch count held zero during reset
// - Zero batch set: count, no output
// - Batch count wraps after 999999
// - Set lowered below count asserts output
// - Backup restores batch output after power
// - Batch accepts pulses up to 5 kHz
// - Dual value is sum or difference
// - Difference only with four output modes
// - Each reset clears its own channel
// - Panel reset clears both, blocks counting
// - Channel in reset counts zero, holds
// - Dual and channel value ranges
// - Channel overflow shows FFFFFF, halts counting
// - Twin: independent counters, panel clears shown
// - Twin shares one prescale register
// - Dual inputs act like increment input
`timescale 1ns/1ps
module mce_counter #(
  parameter int          ADDR_W  = 8,
  parameter logic [20:0] CNT_MAX = mce_pkg::MCE_MAX
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output      logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output      logic              s_axi_wready,
  output      logic [1:0]        s_axi_bresp,
  output      logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output      logic              s_axi_arready,
  output      logic [31:0]       s_axi_rdata,
  output      logic [1:0]        s_axi_rresp,
  output      logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              count_input_a,
  input  wire logic              count_input_b,
  input  wire logic              reset_a_in,
  input  wire logic              reset_b_in,
  input  wire logic              backup_valid,
  output      logic              control_out,
  output      logic              batch_out,
  output      logic              overflow
);

  localparam int VW = mce_pkg::MCE_VW;

  // Signed-range helpers, 21-bit two's complement
  function automatic logic [20:0] inc_wrap(input logic [20:0] v);
    inc_wrap = (v == CNT_MAX) ? mce_pkg::MCE_ZERO : 21'(v + mce_pkg::MCE_ONE);
  endfunction : inc_wrap

  function automatic logic [20:0] dec_sat(input logic [20:0] v);
    dec_sat = (v == mce_pkg::MCE_NEG_MIN) ? v : 21'(v - mce_pkg::MCE_ONE);
  endfunction : dec_sat

  // Three-stage input synchronisers
  logic [2:0] sa_q;
  logic [2:0] sb_q;
  logic [2:0] ra_q;
  logic [2:0] rb_q;
  logic       ca_st_q;
  logic       cb_st_q;
  logic       ra_st_q;
  logic       rb_st_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sa_q <= 3'h0;
      sb_q <= 3'h0;
      ra_q <= 3'h0;
      rb_q <= 3'h0;
    end else begin
      sa_q <= {sa_q[1:0], count_input_a};
      sb_q <= {sb_q[1:0], count_input_b};
      ra_q <= {ra_q[1:0], reset_a_in};
      rb_q <= {rb_q[1:0], reset_b_in};
    end
  end

  // Stable level updates only when stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ca_st_q <= 1'b0;
      cb_st_q <= 1'b0;
      ra_st_q <= 1'b0;
      rb_st_q <= 1'b0;
    end else begin
      if (sa_q[1] == sa_q[2]) ca_st_q <= sa_q[2];
      if (sb_q[1] == sb_q[2]) cb_st_q <= sb_q[2];
      if (ra_q[1] == ra_q[2]) ra_st_q <= ra_q[2];
      if (rb_q[1] == rb_q[2]) rb_st_q <= rb_q[2];
    end
  end

  // Edge at 125 MHz easily covers 5 kHz pulses
  wire edge_a = (sa_q[1] == sa_q[2]) && sa_q[2] && !ca_st_q;
  wire edge_b = (sb_q[1] == sb_q[2]) && sb_q[2] && !cb_st_q;
  wire rst_a  = ra_st_q;
  wire rst_b  = rb_st_q;

  // Registers
  logic [31:0]   ctrl_q;
  logic [VW-1:0] set_q;
  logic [VW-1:0] bset_q;
  logic [VW-1:0] pv_a_q;
  logic [VW-1:0] pv_b_q;
  logic [VW-1:0] total_q;
  logic [VW-1:0] batch_q;
  logic          ctl_q;
  logic          bout_q;
  logic          ovf_q;
  logic          panel_q;
  logic          keep_q;
  logic          first_q;
  logic [15:0]   presc_q;

  wire mce_pkg::mce_cfg_t cfg = mce_pkg::mce_cfg_t'(ctrl_q[mce_pkg::MCE_C_CFG +: 2]);
  wire mce_pkg::mce_scr_t scr = mce_pkg::mce_scr_t'(ctrl_q[mce_pkg::MCE_C_SCR +: 2]);
  wire [2:0] omode  = ctrl_q[mce_pkg::MCE_C_OMODE +: 3];
  wire       down   = ctrl_q[mce_pkg::MCE_C_DOWN];
  wire       backup = ctrl_q[mce_pkg::MCE_C_BACKUP];

  wire sub_ok = (omode == mce_pkg::MCE_OM_K2) || (omode == mce_pkg::MCE_OM_D) ||
                (omode == mce_pkg::MCE_OM_L) || (omode == mce_pkg::MCE_OM_H);
  wire sub_md = ctrl_q[mce_pkg::MCE_C_SUB] && sub_ok;

  wire is_dual  = (cfg == mce_pkg::MCE_CFG_DUAL);
  wire is_twin  = (cfg == mce_pkg::MCE_CFG_TWIN);
  wire is_batch = (cfg == mce_pkg::MCE_CFG_BATCH);
  wire is_total = (cfg == mce_pkg::MCE_CFG_TOTAL);

  // Panel reset pulse decoded per screen
  wire pnl_all  = panel_q && (is_dual || (!is_twin && scr == mce_pkg::MCE_SCR_MAIN));
  wire pnl_aux  = panel_q && scr == mce_pkg::MCE_SCR_AUX && (is_total || is_batch);
  wire pnl_tw_a = panel_q && is_twin && scr != mce_pkg::MCE_SCR_CH_B;
  wire pnl_tw_b = panel_q && is_twin && scr == mce_pkg::MCE_SCR_CH_B;

  // Dual value uses zero for a channel in reset
  wire [VW-1:0] opa  = rst_a ? mce_pkg::MCE_ZERO : pv_a_q;
  wire [VW-1:0] opb  = rst_b ? mce_pkg::MCE_ZERO : pv_b_q;
  wire [VW-1:0] dual = sub_md ? 21'(opa - opb) : 21'(opa + opb);

  // Channel clear and count enables; overflow halts all counting
  wire clr_a = rst_a || pnl_all || pnl_aux || pnl_tw_a;
  wire clr_b_dual = (is_dual || is_twin) && (rst_b || pnl_all || pnl_tw_b);
  wire cnt_ok = !ovf_q && !panel_q;
  wire up_a   = edge_a && !clr_a && cnt_ok;
  wire up_b   = edge_b && !rst_b && cnt_ok && (is_dual || is_twin);
  wire chan   = is_dual || is_twin;
  wire dn_a   = down && !chan;

  wire a_over = chan && up_a && (pv_a_q == CNT_MAX);
  wire b_over = up_b && (pv_b_q == CNT_MAX);

  // Completion: present value arrives at the set value
  wire [VW-1:0] pv_a_nx = dn_a ? dec_sat(pv_a_q) : inc_wrap(pv_a_q);
  wire          done_a  = up_a && (pv_a_nx == set_q);
  wire          dual_hit = is_dual && (dual == set_q) && !pnl_all;
  wire          ctl_clr  = pnl_all || pnl_aux || (rst_a && !chan);
  wire          batch_clr = is_batch && (rst_b || pnl_aux);

  // Batch output reacts to count reaching set, or set lowered under it
  wire bout_set = is_batch && (bset_q != mce_pkg::MCE_ZERO) &&
                  (batch_q >= bset_q) && !rst_b && !pnl_aux;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pv_a_q <= mce_pkg::MCE_ZERO;
      pv_b_q <= mce_pkg::MCE_ZERO;
      ovf_q  <= 1'b0;
      ctl_q  <= 1'b0;
    end else begin
      if (clr_a) begin
        pv_a_q <= mce_pkg::MCE_ZERO;
      end else if (up_a && !a_over) begin
        pv_a_q <= pv_a_nx;
      end
      if (clr_b_dual) begin
        pv_b_q <= mce_pkg::MCE_ZERO;
      end else if (up_b && !b_over) begin
        pv_b_q <= inc_wrap(pv_b_q);
      end
      if (pnl_all || pnl_aux) begin
        ovf_q <= 1'b0;
      end else if (is_dual && (a_over || b_over)) begin
        ovf_q <= 1'b1;
      end
      if (ctl_clr) begin
        ctl_q <= 1'b0;
      end else if (done_a || dual_hit) begin
        ctl_q <= 1'b1;
      end
    end
  end

  // Total accumulates regardless of reset one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      total_q <= mce_pkg::MCE_ZERO;
    end else if ((is_total && rst_b) || pnl_aux && is_total) begin
      total_q <= mce_pkg::MCE_ZERO;
    end else if (is_total && edge_a && cnt_ok) begin
      total_q <= down ? dec_sat(total_q) : inc_wrap(total_q);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      batch_q <= mce_pkg::MCE_ZERO;
      bout_q  <= 1'b0;
    end else begin
      if (batch_clr) begin
        batch_q <= mce_pkg::MCE_ZERO;
      end else if (is_batch && done_a) begin
        batch_q <= inc_wrap(batch_q);
      end
      if (batch_clr) begin
        bout_q <= 1'b0;
      end else if (bout_set || (first_q && backup_valid && keep_q)) begin
        bout_q <= 1'b1;
      end
    end
  end

  // Kept through aresetn so a backed-up batch output returns once, on the first cycle
  always_ff @(posedge aclk) begin
    first_q <= !aresetn;
    if (aresetn) begin
      keep_q <= bout_q && backup;
    end
  end

  // AXI4-Lite slave, one access at a time each direction
  logic              aw_q;
  logic              w_q;
  logic              bv_q;
  logic              rv_q;
  logic [ADDR_W-1:0] awa_q;
  logic [31:0]       wd_q;
  logic [31:0]       rd_q;
  logic [1:0]        br_q;
  logic [1:0]        rr_q;

  assign s_axi_awready = !aw_q && !bv_q;
  assign s_axi_wready  = !w_q && !bv_q;
  assign s_axi_arready = !rv_q;
  wire   wr_go = aw_q && w_q && !bv_q;
  wire [7:0] wa = 8'(awa_q);
  wire [7:0] ra = 8'(s_axi_araddr);
  wire   wr_ctrl = wr_go && wa == mce_pkg::MCE_REG_CTRL;
  wire   wr_hit  = wr_ctrl || wa == mce_pkg::MCE_REG_SET || wa == mce_pkg::MCE_REG_BSET ||
                   wa == mce_pkg::MCE_REG_PRESC;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q    <= 1'b0;
      w_q     <= 1'b0;
      bv_q    <= 1'b0;
      awa_q   <= '0;
      wd_q    <= 32'h0;
      br_q    <= mce_pkg::MCE_RESP_OK;
      ctrl_q  <= 32'h0;
      set_q   <= mce_pkg::MCE_ZERO;
      bset_q  <= mce_pkg::MCE_ZERO;
      presc_q <= 16'h0;
      panel_q <= 1'b0;
    end else begin
      panel_q <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q  <= 1'b1;
        awa_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q  <= 1'b1;
        wd_q <= s_axi_wdata;
      end
      if (wr_go) begin
        aw_q <= 1'b0;
        w_q  <= 1'b0;
        bv_q <= 1'b1;
        br_q <= wr_hit ? mce_pkg::MCE_RESP_OK : mce_pkg::MCE_RESP_SLVERR;
        if (wr_ctrl) begin
          ctrl_q  <= {wd_q[31:9], 1'b0, wd_q[7:0]};
          panel_q <= wd_q[mce_pkg::MCE_C_PANEL];
        end
        if (wa == mce_pkg::MCE_REG_SET)   set_q   <= wd_q[VW-1:0];
        if (wa == mce_pkg::MCE_REG_BSET)  bset_q  <= wd_q[VW-1:0];
        if (wa == mce_pkg::MCE_REG_PRESC) presc_q <= wd_q[15:0];
      end else if (bv_q && s_axi_bready) bv_q <= 1'b0;
    end
  end

  function automatic logic [31:0] sx(input logic [20:0] v);
    sx = {{11{v[20]}}, v};
  endfunction : sx

  wire [31:0] stat = {29'h0, ovf_q, bout_q, ctl_q};
  wire [31:0] pva_show = ovf_q ? {8'h00, mce_pkg::MCE_OVF_SHOW} : sx(pv_a_q);
  wire [31:0] rsel =
    (ra == mce_pkg::MCE_REG_CTRL)  ? ctrl_q :
    (ra == mce_pkg::MCE_REG_SET)   ? sx(set_q) :
    (ra == mce_pkg::MCE_REG_BSET)  ? sx(bset_q) :
    (ra == mce_pkg::MCE_REG_PV_A)  ? pva_show :
    (ra == mce_pkg::MCE_REG_PV_B)  ? (ovf_q ? {8'h00, mce_pkg::MCE_OVF_SHOW} : sx(pv_b_q)) :
    (ra == mce_pkg::MCE_REG_TOTAL) ? sx(total_q) :
    (ra == mce_pkg::MCE_REG_BATCH) ? sx(batch_q) :
    (ra == mce_pkg::MCE_REG_DUAL)  ? sx(dual) :
    (ra == mce_pkg::MCE_REG_STAT)  ? stat :
    (ra == mce_pkg::MCE_REG_PRESC) ? {16'h0, presc_q} : 32'h0;
  wire rd_hit = ra <= mce_pkg::MCE_REG_PRESC && ra[1:0] == 2'b00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rv_q <= 1'b0;
      rd_q <= 32'h0;
      rr_q <= mce_pkg::MCE_RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rv_q <= 1'b1;
      rd_q <= rd_hit ? rsel : 32'h0;
      rr_q <= rd_hit ? mce_pkg::MCE_RESP_OK : mce_pkg::MCE_RESP_SLVERR;
    end else if (rv_q && s_axi_rready) begin
      rv_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bv_q;
  assign s_axi_bresp  = br_q;
  assign s_axi_rvalid = rv_q;
  assign s_axi_rdata  = rd_q;
  assign s_axi_rresp  = rr_q;
  assign control_out  = ctl_q;
  assign batch_out    = bout_q;
  assign overflow     = ovf_q;

endmodule : mce_counter

//--- logic/mce_pkg.sv
package mce_pkg;

  // Configurations of the counter block
  typedef enum logic [1:0] {
    MCE_CFG_TOTAL = 2'b00,
    MCE_CFG_BATCH = 2'b01,
    MCE_CFG_DUAL  = 2'b10,
    MCE_CFG_TWIN  = 2'b11
  } mce_cfg_t;

  // Screen currently shown, selects what the panel reset clears
  typedef enum logic [1:0] {
    MCE_SCR_MAIN  = 2'b00,
    MCE_SCR_AUX   = 2'b01,
    MCE_SCR_CH_A  = 2'b10,
    MCE_SCR_CH_B  = 2'b11
  } mce_scr_t;

  localparam int          MCE_VW        = 21;
  localparam int          MCE_AW        = 8;
  localparam logic [20:0] MCE_MAX       = 21'h0F423F;
  localparam logic [20:0] MCE_NEG_MIN   = 21'h1E7961;
  localparam logic [20:0] MCE_ZERO      = 21'h000000;
  localparam logic [20:0] MCE_ONE       = 21'h000001;
  localparam logic [23:0] MCE_OVF_SHOW  = 24'hFFFFFF;

  // Register byte offsets
  localparam logic [7:0] MCE_REG_CTRL   = 8'h00;
  localparam logic [7:0] MCE_REG_SET    = 8'h04;
  localparam logic [7:0] MCE_REG_BSET   = 8'h08;
  localparam logic [7:0] MCE_REG_PV_A   = 8'h0C;
  localparam logic [7:0] MCE_REG_PV_B   = 8'h10;
  localparam logic [7:0] MCE_REG_TOTAL  = 8'h14;
  localparam logic [7:0] MCE_REG_BATCH  = 8'h18;
  localparam logic [7:0] MCE_REG_DUAL   = 8'h1C;
  localparam logic [7:0] MCE_REG_STAT   = 8'h20;
  localparam logic [7:0] MCE_REG_PRESC  = 8'h24;

  // CTRL fields
  localparam int MCE_C_CFG    = 0;
  localparam int MCE_C_SCR    = 2;
  localparam int MCE_C_SUB    = 4;
  localparam int MCE_C_DOWN   = 5;
  localparam int MCE_C_BACKUP = 6;
  localparam int MCE_C_PANEL  = 8;
  localparam int MCE_C_OMODE  = 12;

  // Output modes; K2, D, L and H allow difference mode
  localparam logic [2:0] MCE_OM_K2 = 3'h0;
  localparam logic [2:0] MCE_OM_D  = 3'h1;
  localparam logic [2:0] MCE_OM_L  = 3'h2;
  localparam logic [2:0] MCE_OM_H  = 3'h3;
  localparam logic [2:0] MCE_OM_N  = 3'h4;

  localparam logic [1:0] MCE_RESP_OK     = 2'b00;
  localparam logic [1:0] MCE_RESP_SLVERR = 2'b10;

endpackage : mce_pkg

//--- verification/mce_counter_sva.sv
`timescale 1ns/1ps
module mce_counter_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic count_input_a,
  input wire logic count_input_b,
  input wire logic reset_a_in,
  input wire logic reset_b_in,
  input wire logic control_out,
  input wire logic batch_out,
  input wire logic overflow
);
  logic [3:0] quiet_q;
  logic [3:0] cause_q;
  // Outputs may only move shortly after a reset input, a write or a pulse
  wire        stir = !aresetn || reset_a_in || reset_b_in || s_axi_bvalid;
  wire        poke = stir || count_input_a || count_input_b;
  always_ff @(posedge aclk) begin
    quiet_q <= stir ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'hF};
    cause_q <= poke ? 4'h0 : cause_q + {3'h0, cause_q != 4'hF};
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_rst_quiet: assert property (disable iff (1'b0)
    !aresetn |=> !control_out && !batch_out && !overflow) else $error("outputs not cleared");
  a_rst_ready: assert property ($rose(aresetn) |=> s_axi_awready && s_axi_wready && s_axi_arready)
    else $error("ready low after reset");
  a_wr_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid) else $error("late write response");
  a_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid) else $error("late read data");
  a_batch_held: assert property (
    $fell(batch_out) |-> quiet_q < 4'h8) else $error("batch output dropped alone");
  a_ovf_sticky: assert property (
    $fell(overflow) |-> quiet_q < 4'h8) else $error("overflow dropped alone");
  a_ctl_cause: assert property (
    $rose(control_out) |-> cause_q < 4'h8) else $error("control output without cause");
  a_batch_cause: assert property (
    $rose(batch_out) |-> cause_q < 4'h8) else $error("batch output without cause");
endmodule : mce_counter_sva
bind mce_counter mce_counter_sva mce_counter_sva_i (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .count_input_a, .count_input_b, .reset_a_in, .reset_b_in, .control_out,
  .batch_out, .overflow);

//--- verification/mce_pulse_src.sv
`timescale 1ns/1ps
module mce_pulse_src #(
  parameter int HALF = 5
) (
  input  wire logic       aclk,
  input  wire logic [7:0] n,
  input  wire logic       go,
  output      logic       busy,
  output      logic       pulse
);
  // Push-pull sensor line, rests low between bursts
  initial begin
    pulse = 1'b0;
    busy  = 1'b0;
    forever begin
      @(posedge aclk);
      if (go && n != 8'h00) begin
        busy <= 1'b1;
        for (int i = 0; i < int'(n); i++) begin
          pulse <= 1'b1;
          repeat (HALF) @(posedge aclk);
          pulse <= 1'b0;
          repeat (HALF) @(posedge aclk);
        end
        busy <= 1'b0;
      end
    end
  end
endmodule : mce_pulse_src

//--- verification/multi_config_event_counter_tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; \
  $display("mismatch t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module multi_config_event_counter_tb_top;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, count_input_a, count_input_b, reset_a_in, reset_b_in;
  logic        backup_valid, control_out, batch_out, overflow, go, busy_a, busy_b;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, na, nb, n;
  logic [31:0] s_axi_wdata, s_axi_rdata, rng;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  int          failures, checked;
  // Small count ceiling so wrap and overflow are reachable in a short run
  localparam logic [20:0] TB_MAX = 21'h000014;
  mce_counter #(.CNT_MAX(TB_MAX)) mce_counter_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .count_input_a, .count_input_b, .reset_a_in, .reset_b_in,
    .backup_valid, .control_out, .batch_out, .overflow);
  mce_pulse_src mce_pulse_src_i (.aclk, .n(na), .go, .busy(busy_a), .pulse(count_input_a));
  mce_pulse_src mce_pulse_src_b_i (.aclk, .n(nb), .go, .busy(busy_b), .pulse(count_input_b));
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : xs
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    repeat (2) @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] v,
                    input logic [1:0] r = mce_pkg::MCE_RESP_OK);
    exp_q.push_back({r, v});
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
  endtask : rd
  task automatic pulse(input logic [7:0] a, input logic [7:0] b);
    na <= a;
    nb <= b;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    repeat (2) @(posedge aclk);
    while (busy_a || busy_b) @(posedge aclk);
    repeat (6) @(posedge aclk);
  endtask : pulse
  // Synchronisers need the level for several cycles
  task automatic hold_rst(input logic a, input logic b, input logic rel);
    reset_a_in <= a;
    reset_b_in <= b;
    repeat (6) @(posedge aclk);
    if (rel) hold_rst(1'b0, 1'b0, 1'b0);
  endtask : hold_rst
  task automatic print_verdict();
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      e = exp_q.pop_front();
      `CHK({s_axi_rresp, s_axi_rdata}, e)
    end
  end
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    print_verdict();
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, go, reset_a_in, reset_b_in} = '0;
    {s_axi_awaddr, s_axi_araddr, na, nb, s_axi_wdata, backup_valid} = '0;
    {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3F;
    {failures, checked} = '0;
    rng = 32'h000110D5;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    n = 8'(xs() & 32'h7) + 8'h01;
    wr(mce_pkg::MCE_REG_SET, {24'h000000, n});
    wr(mce_pkg::MCE_REG_CTRL, 32'h00000000);
    pulse(n, 8'h00);
    `CHK(control_out, 1'b1)
    rd(mce_pkg::MCE_REG_TOTAL, {24'h000000, n});
    hold_rst(1'b1, 1'b0, 1'b1);
    rd(mce_pkg::MCE_REG_PV_A, 32'h00000000);
    pulse(8'h02, 8'h00);
    rd(mce_pkg::MCE_REG_TOTAL, {24'h000000, n + 8'h02});
    wr(mce_pkg::MCE_REG_CTRL, 32'h00000104);
    rd(mce_pkg::MCE_REG_TOTAL, 32'h00000000);
    rd(mce_pkg::MCE_REG_PV_A, 32'h00000000);
    `CHK(control_out, 1'b0)
    pulse(8'h01, 8'h00);
    hold_rst(1'b0, 1'b1, 1'b1);
    rd(mce_pkg::MCE_REG_TOTAL, 32'h00000000);
    pulse(8'(TB_MAX) + 8'h02, 8'h00);
    rd(mce_pkg::MCE_REG_TOTAL, 32'h00000001);
    $display("total test done");
    wr(mce_pkg::MCE_REG_CTRL, 32'h00000105);
    wr(mce_pkg::MCE_REG_SET, 32'h00000002);
    wr(mce_pkg::MCE_REG_BSET, 32'h00000005);
    pulse(8'h02, 8'h00);
    rd(mce_pkg::MCE_REG_BATCH, 32'h00000001);
    `CHK(batch_out, 1'b0)
    wr(mce_pkg::MCE_REG_BSET, 32'h00000001);
    `CHK(batch_out, 1'b1)
    wr(mce_pkg::MCE_REG_BSET, 32'h00000007);
    `CHK(batch_out, 1'b1)
    hold_rst(1'b0, 1'b1, 1'b0);
    rd(mce_pkg::MCE_REG_BATCH, 32'h00000000);
    `CHK(batch_out, 1'b0)
    hold_rst(1'b0, 1'b0, 1'b0);
    wr(mce_pkg::MCE_REG_CTRL, 32'h00000105);
    wr(mce_pkg::MCE_REG_BSET, 32'h00000000);
    pulse(8'h02, 8'h00);
    rd(mce_pkg::MCE_REG_BATCH, 32'h00000001);
    `CHK(batch_out, 1'b0)
    wr(mce_pkg::MCE_REG_CTRL, 32'h00000105);
    rd(mce_pkg::MCE_REG_BATCH, 32'h00000000);
    rd(mce_pkg::MCE_REG_PV_A, 32'h00000000);
    wr(mce_pkg::MCE_REG_CTRL, 32'h00000145);
    wr(mce_pkg::MCE_REG_BSET, 32'h00000001);
    pulse(8'h02, 8'h00);
    `CHK(batch_out, 1'b1)
    backup_valid <= 1'b1;
    aresetn      <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    `CHK(batch_out, 1'b1)
    backup_valid <= 1'b0;
    wr(mce_pkg::MCE_REG_SET, 32'h00000002);
    $display("batch test done");
    wr(mce_pkg::MCE_REG_CTRL, 32'h00000012);
    pulse(8'h05, 8'h02);
    rd(mce_pkg::MCE_REG_PV_B, 32'h00000002);
    rd(mce_pkg::MCE_REG_DUAL, 32'h00000003);
    hold_rst(1'b0, 1'b1, 1'b0);
    rd(mce_pkg::MCE_REG_DUAL, 32'h00000005);
    pulse(8'h01, 8'h01);
    rd(mce_pkg::MCE_REG_PV_A, 32'h00000006);
    rd(mce_pkg::MCE_REG_PV_B, 32'h00000000);
    hold_rst(1'b0, 1'b0, 1'b0);
    pulse(8'h00, 8'h08);
    rd(mce_pkg::MCE_REG_DUAL, 32'hFFFFFFFE);
    wr(mce_pkg::MCE_REG_CTRL, 32'h00000112);
    rd(mce_pkg::MCE_REG_DUAL, 32'h00000000);
    `CHK(control_out, 1'b0)
    wr(mce_pkg::MCE_REG_CTRL, 32'h00004012);
    pulse(8'h01, 8'h01);
    rd(mce_pkg::MCE_REG_DUAL, 32'h00000002);
    pulse(8'(TB_MAX), 8'h00);
    `CHK(overflow, 1'b1)
    rd(mce_pkg::MCE_REG_PV_A, 32'h00FFFFFF);
    pulse(8'h00, 8'h01);
    rd(mce_pkg::MCE_REG_DUAL, {11'h000, TB_MAX + 21'h000001});
    wr(mce_pkg::MCE_REG_CTRL, 32'h00004112);
    `CHK(overflow, 1'b0)
    $display("dual test done");
    wr(mce_pkg::MCE_REG_CTRL, 32'h0000010B);
    wr(mce_pkg::MCE_REG_CTRL, 32'h0000010F);
    pulse(8'h02, 8'h03);
    rd(mce_pkg::MCE_REG_PV_B, 32'h00000003);
    wr(mce_pkg::MCE_REG_CTRL, 32'h0000010F);
    rd(mce_pkg::MCE_REG_PV_A, 32'h00000002);
    rd(mce_pkg::MCE_REG_PV_B, 32'h00000000);
    n = 8'(xs());
    wr(mce_pkg::MCE_REG_PRESC, {24'h000000, n});
    rd(mce_pkg::MCE_REG_PRESC, {24'h000000, n});
    rd(8'h3C, 32'h00000000, mce_pkg::MCE_RESP_SLVERR);
    @(posedge aclk);
    $display("twin test done");
    print_verdict();
  end
endmodule : multi_config_event_counter_tb_top
